//--- sim/bscf_motor_model.sv
// Motor winding model: back-EMF comparator levels seen at the three phases
`timescale 1ns/1ps
module bscf_motor_model (
   input  wire logic       clk,
   input  wire logic       spin,
   input  wire logic [7:0] lag,
   input  wire logic [5:0] drive,
   output logic      [2:0] cmp
);
   logic [5:0] last = 6'h00;
   logic [7:0] cnt  = 8'h00;
   logic       tgl  = 1'b0;
   logic [2:0] oe;
   logic [2:0] src;
   logic [2:0] succ;
   // Bit 2 is phase A, bit 0 is phase C
   assign oe   = {drive[5], drive[3], drive[1]};
   assign src  = oe & {drive[4], drive[2], drive[0]};
   assign succ = {src[1], src[0], src[2]};
   always_ff @(posedge clk) begin
      last <= drive;
      tgl  <= ~tgl;
      cnt  <= (drive != last) ? 8'h00 : ((cnt == 8'hff) ? cnt : cnt + 8'h01);
   end
   // A floating phase crosses the centertap only once the rotor has turned;
   // with nothing driven the comparators see noise, never a held level
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (oe[i])
            cmp[i] = src[i];
         else if (oe == 3'b000)
            cmp[i] = tgl;
         else
            cmp[i] = (spin && cnt >= lag) ? succ[i] : ~succ[i];
      end
   end
endmodule : bscf_motor_model

//--- sim/test_bldc_sensorless_commutation_fll.sv
// Self-checking bench: bus, sequencer, timers, current limit and speed window
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("[FAIL] %0t got %h expected %h", $time, (a), (e)); end end
module test_bldc_sensorless_commutation_fll;
   import bscf_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, refOscClock = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rs = 32'd95;
   logic [1:0]  htrans = 2'b00;
   logic [10:0] currentReq = 11'h000, currentCmd;
   logic        hreadyout, hresp, diagOut, speedUp, slowDown, spin = 1'b0, mon = 1'b0;
   logic        pAO, pAE, pBO, pBE, pCO, pCE, prevD;
   logic [2:0]  cmp;
   logic [7:0]  lag = 8'd30;
   bscf_seq_t   seqState, prevS;
   int          fail_count = 0, num_checks = 0, cyc = 0, iv = 0, ivMin = 0, ivMax = 0;
   int          steps = 0, tog = 0, w;
   initial begin
      forever #10 clk = ~clk;
   end
   bscf_top dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bemfCmpA(cmp[2]),
      .bemfCmpB(cmp[1]), .bemfCmpC(cmp[0]), .refOscClock(refOscClock),
      .currentReq(currentReq), .phaseAOut(pAO), .phaseAOe(pAE), .phaseBOut(pBO),
      .phaseBOe(pBE), .phaseCOut(pCO), .phaseCOe(pCE), .currentCmd(currentCmd),
      .diagOut(diagOut), .speedUp(speedUp), .slowDown(slowDown), .seqState(seqState));
   bscf_motor_model motor (.clk(clk), .spin(spin), .lag(lag),
      .drive({pAE, pAO & pAE, pBE, pBO & pBE, pCE, pCO & pCE}), .cmp(cmp));
   // ----------------------------------------
   // Expectation helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs
   function automatic logic [5:0] drv(input logic [2:0] s);
      logic [5:0] t [6] = '{6'b111000, 6'b001011, 6'b100011, 6'b101100, 6'b001110, 6'b110010};
      return t[s];
   endfunction : drv
   function automatic logic [10:0] lim(input logic [1:0] c, input logic [10:0] r);
      logic [10:0] l [4] = '{11'd2047, 11'd1000, 11'd800, 11'd600};
      return (r < l[c]) ? r : l[c];
   endfunction : lim
   function automatic logic [31:0] cfg(input logic [1:0] m, input logic [1:0] il,
                                       input logic [13:0] spd, input logic [1:0] dg,
                                       input logic [1:0] pl);
      return {8'h00, dg[0], dg[1], pl[0], pl[1], 1'b0, spd, il[0], il[1], 1'b0, m};
   endfunction : cfg
   // ----------------------------------------
   // Bus master and run control
   // ----------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task automatic run(input logic [31:0] c, input int lo, input int hi, input int n);
      bus(1'b1, 8'h00, 32'h0);
      repeat (4) @(posedge clk);
      prevS = seqState;
      prevD = diagOut;
      {steps, tog, iv, ivMin, ivMax} = {32'd0, 32'd0, 32'd0, lo, hi};
      mon = 1'b1;
      bus(1'b1, 8'h00, c);
      for (w = 0; w < 20000 && steps < n; w++) @(posedge clk);
      mon = 1'b0;
      `CHK(steps >= n, 1'b1)
   endtask : run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 5 == 4) refOscClock <= ~refOscClock;
      if (cyc == 60000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   always @(negedge clk) begin
      if (mon) begin
         iv++;
         if (seqState !== prevS) begin
            `CHK(seqState, bscf_seq_t'((prevS == SEQ_S6) ? 3'd0 : prevS + 3'd1))
            if (steps > 0 && ivMax > 0) `CHK(iv >= ivMin && iv <= ivMax, 1'b1)
            steps++;
            iv = 0;
            prevS = seqState;
         end
         if (steps > 0) `CHK({pAE, pAO & pAE, pBE, pBO & pBE, pCE, pCO & pCE}, drv(seqState))
         if (diagOut !== prevD) tog++;
         prevD = diagOut;
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin : main
      logic [7:0]  ad [5] = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'h18};
      logic [31:0] rv [5] = '{32'd100000, 32'd1000, 32'd20000, 32'h40, 32'h0};
      logic [31:0] nv [5] = '{32'd600, 32'd5, 32'd50, 32'd4, 32'h0};
      logic [10:0] rq;
      logic [2:0]  k;
      int          refCnt;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      `CHK({pAE, pBE, pCE, hresp, hreadyout, seqState}, {5'b00001, SEQ_S1})
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, ad[i], 32'h0);
         `CHK(rd, rv[i])
         bus(1'b1, ad[i], nv[i]);
         bus(1'b0, ad[i], 32'h0);
         `CHK(rd, nv[i])
      end
      // Stalled rotor: only the watchdog moves the sequencer
      run(cfg(2'b01, 2'b00, 14'h3fff, 2'b11, 2'b00), 49, 54, 13);
      `CHK(tog, 0)
      // Step-only mode with the watchdog out of reach: startup timer steps
      bus(1'b1, 8'h0c, 32'd1000);
      bus(1'b1, 8'h04, 32'd120);
      run(cfg(2'b11, 2'b00, 14'h3fff, 2'b11, 2'b00), 119, 124, 8);
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 8'h00, cfg(2'b00, c[1:0], 14'h3fff, 2'b11, 2'b00));
         for (int j = 0; j < 3; j++) begin
            rq = (j == 0) ? 11'(xs()) : lim(c[1:0], 11'h7ff) + 11'(j - 2);
            currentReq <= rq;
            repeat (3) @(posedge clk);
            `CHK(currentCmd, lim(c[1:0], rq))
         end
      end
      // Turning rotor: crossings time the commutation, the toggle reaches the pin
      bus(1'b1, 8'h0c, 32'd400);
      bus(1'b1, 8'h04, 32'd600);
      spin = 1'b1;
      run(cfg(2'b01, 2'b00, 14'h3fff, 2'b11, 2'b00), 31, 399, 30);
      `CHK(tog >= steps - 2 && tog <= steps, 1'b1)
      k = 3'(xs());
      k = (k == 3'd0) ? 3'd5 : k;
      // Oscillator at 5 MHz; this speed asks for a count of 16k cycles
      refCnt = 60 * 5000000 / (18750000 / k);
      // Sixteen poles: about 200 crossings give four or five revolution toggles
      run(cfg(2'b01, 2'b00, ~14'(refCnt / 16), 2'b00, 2'b10), 0, 0, 200);
      `CHK(tog >= 4 && tog <= 5, 1'b1)
      bus(1'b1, 8'h00, cfg(2'b01, 2'b00, ~14'(refCnt / 16), 2'b10, 2'b10));
      for (w = 0; w < 20000 && diagOut !== 1'b0; w++) @(posedge clk);
      for (w = 0; w < 20000 && diagOut !== 1'b1; w++) @(posedge clk);
      for (w = 0; w < 20000 && diagOut === 1'b1; w++) @(posedge clk);
      `CHK(w >= 160 * k - 12 && w <= 160 * k + 12, 1'b1)
      @(negedge clk);
      `CHK({speedUp, slowDown}, 2'b10)
      tally_and_finish();
   end
endmodule : test_bldc_sensorless_commutation_fll

//--- src/bscf_defs.svh
// Register map, field positions, reset values and timing constants
`ifndef BSCF_DEFS_SVH
`define BSCF_DEFS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BSCF_OFS_CTRL    8'h00
`define BSCF_OFS_STARTUP 8'h04
`define BSCF_OFS_BLANK   8'h08
`define BSCF_OFS_WDOG    8'h0c
`define BSCF_OFS_STATUS  8'h10
`define BSCF_OFS_ADV     8'h14
// ----------------------------------------
// Configuration word fields
// ----------------------------------------
`define BSCF_RUN_BIT   0
`define BSCF_STEP_BIT  1
`define BSCF_ILIM_HI   3
`define BSCF_ILIM_LO   4
`define BSCF_SPD_LSB   5
`define BSCF_SPD_MSB   18
`define BSCF_POLE_HI   20
`define BSCF_POLE_LO   21
`define BSCF_DIAG_HI   22
`define BSCF_DIAG_LO   23
`define BSCF_CFG_W     24
// ----------------------------------------
// Timing
// ----------------------------------------
`define BSCF_CLK_MHZ     50
`define BSCF_STARTUP_US  2000
`define BSCF_BLANK_US    20
`define BSCF_WDOG_US     400
`define BSCF_TMR_W       20
`define BSCF_ADV_RST     20'h00040
`define BSCF_XING_8P     6'h18
`define BSCF_XING_12P    6'h24
`define BSCF_XING_16P    6'h30
// ----------------------------------------
// Current limits in mA
// ----------------------------------------
`define BSCF_ILIM_SAT   11'h7ff
`define BSCF_ILIM_1A    11'h3e8
`define BSCF_ILIM_800   11'h320
`define BSCF_ILIM_600   11'h258
`endif

//--- src/bscf_pkg.sv
// Types shared by the commutation block
package bscf_pkg;
   typedef enum logic [2:0] {SEQ_S1, SEQ_S2, SEQ_S3, SEQ_S4, SEQ_S5, SEQ_S6} bscf_seq_t;
   typedef logic [19:0] bscf_tmr_t;
endpackage : bscf_pkg

//--- src/bscf_ref_window.sv
// Speed reference window timed in reference oscillator cycles
`timescale 1ns/1ps
module bscf_ref_window (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        oscRise,
   input  wire logic        start,
   input  wire logic [17:0] winLen,
   output logic             window,
   output logic             windowFall
);
   logic [17:0] cnt_r;
   wire         lastTick = oscRise && (cnt_r == 18'h00001);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r      <= 18'h00000;
         window     <= 1'b0;
         windowFall <= 1'b0;
      end else begin
         windowFall <= window && lastTick && !start;
         if (start && winLen != 18'h00000) begin
            cnt_r  <= winLen;
            window <= 1'b1;
         end else if (window && oscRise) begin
            cnt_r  <= cnt_r - 18'h00001;
            window <= !lastTick;
         end
      end
   end
endmodule : bscf_ref_window

//--- src/bscf_sync.sv
// Three-stage pin synchroniser; a change is accepted once stages two and three agree
`timescale 1ns/1ps
module bscf_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] stableOut
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               s1_r[i]      <= 1'b0;
               s2_r[i]      <= 1'b0;
               s3_r[i]      <= 1'b0;
               stableOut[i] <= 1'b0;
            end else begin
               s1_r[i] <= pinIn[i];
               s2_r[i] <= s1_r[i];
               s3_r[i] <= s2_r[i];
               if (s2_r[i] == s3_r[i]) begin
                  stableOut[i] <= s3_r[i];
               end
            end
         end
      end
   endgenerate
endmodule : bscf_sync

//--- src/bscf_top.sv
// Sensorless commutation sequencer, timers and speed loop with AHB-Lite registers
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "bscf_defs.svh"
module bscf_top (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        bemfCmpA,
   input  wire logic        bemfCmpB,
   input  wire logic        bemfCmpC,
   input  wire logic        refOscClock,
   input  wire logic [10:0] currentReq,
   output logic             phaseAOut,
   output logic             phaseAOe,
   output logic             phaseBOut,
   output logic             phaseBOe,
   output logic             phaseCOut,
   output logic             phaseCOe,
   output logic [10:0]      currentCmd,
   output logic             diagOut,
   output logic             speedUp,
   output logic             slowDown,
   output bscf_pkg::bscf_seq_t seqState
);
   import bscf_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Returns {oeA,hiA,oeB,hiB,oeC,hiC}
   function automatic logic [5:0] driveOf(input bscf_seq_t s);
      unique case (s)
         SEQ_S1: driveOf = 6'b111000;
         SEQ_S2: driveOf = 6'b001011;
         SEQ_S3: driveOf = 6'b100011;
         SEQ_S4: driveOf = 6'b101100;
         SEQ_S5: driveOf = 6'b001110;
         default: driveOf = 6'b110010;
      endcase
   endfunction : driveOf

   function automatic bscf_seq_t nextOf(input bscf_seq_t s);
      nextOf = (s == SEQ_S6) ? SEQ_S1 : bscf_seq_t'(s + 3'h1);
   endfunction : nextOf

   function automatic bscf_tmr_t usToCycles(input int us);
      usToCycles = bscf_tmr_t'(us * `BSCF_CLK_MHZ);
   endfunction : usToCycles

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   logic [`BSCF_CFG_W-1:0] cfg_r;
   bscf_tmr_t              startLen_r;
   bscf_tmr_t              blankLen_r;
   bscf_tmr_t              wdLen_r;
   bscf_tmr_t              advThr_r;
   logic                   wrPend_r;
   logic [7:0]             wrAddr_r;
   logic [31:0]            statusWord;

   wire        addrPhase = hsel && hready && htrans[1];
   wire [7:0]  regAddr   = haddr[7:0];
   wire        wrCtrl    = wrPend_r && wrAddr_r == `BSCF_OFS_CTRL;
   wire        wrStart   = wrPend_r && wrAddr_r == `BSCF_OFS_STARTUP;
   wire        wrBlank   = wrPend_r && wrAddr_r == `BSCF_OFS_BLANK;
   wire        wrWdog    = wrPend_r && wrAddr_r == `BSCF_OFS_WDOG;
   wire        wrAdv     = wrPend_r && wrAddr_r == `BSCF_OFS_ADV;
   wire [31:0] rdMux     =
      (regAddr == `BSCF_OFS_CTRL)    ? {8'h00, cfg_r} :
      (regAddr == `BSCF_OFS_STARTUP) ? {12'h000, startLen_r} :
      (regAddr == `BSCF_OFS_BLANK)   ? {12'h000, blankLen_r} :
      (regAddr == `BSCF_OFS_WDOG)    ? {12'h000, wdLen_r} :
      (regAddr == `BSCF_OFS_ADV)     ? {12'h000, advThr_r} :
      (regAddr == `BSCF_OFS_STATUS)  ? statusWord : 32'h00000000;

   // Zero wait states, so the slave never stretches a transfer
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
         hrdata   <= 32'h00000000;
      end else begin
         wrPend_r <= addrPhase && hwrite;
         wrAddr_r <= regAddr;
         if (addrPhase && !hwrite) begin
            hrdata <= rdMux;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r      <= {`BSCF_CFG_W{1'b0}};
         startLen_r <= usToCycles(`BSCF_STARTUP_US);
         blankLen_r <= usToCycles(`BSCF_BLANK_US);
         wdLen_r    <= usToCycles(`BSCF_WDOG_US);
         advThr_r   <= `BSCF_ADV_RST;
      end else begin
         if (wrCtrl)  cfg_r      <= hwdata[`BSCF_CFG_W-1:0];
         if (wrStart) startLen_r <= hwdata[19:0];
         if (wrBlank) blankLen_r <= hwdata[19:0];
         if (wrWdog)  wdLen_r    <= hwdata[19:0];
         if (wrAdv)   advThr_r   <= hwdata[19:0];
      end
   end

   wire       runEn    = cfg_r[`BSCF_RUN_BIT];
   wire       stepOnly = cfg_r[`BSCF_STEP_BIT];
   wire [1:0] ilimSel  = {cfg_r[`BSCF_ILIM_HI], cfg_r[`BSCF_ILIM_LO]};
   wire [1:0] poleSel  = {cfg_r[`BSCF_POLE_HI], cfg_r[`BSCF_POLE_LO]};
   wire [1:0] diagSel  = {cfg_r[`BSCF_DIAG_HI], cfg_r[`BSCF_DIAG_LO]};
   // Active-low count bits, lowest weighs 16
   wire [17:0] winLen  = {~cfg_r[`BSCF_SPD_MSB:`BSCF_SPD_LSB], 4'h0};
   // Blanking is clipped one cycle under the watchdog
   wire bscf_tmr_t blankEff = (blankLen_r < wdLen_r) ? blankLen_r
                                                     : wdLen_r - 20'h00001;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] pinStable;
   logic       oscPrev_r;

   bscf_sync #(.W(4)) u_sync (
      .clk       (clk),
      .reset_n   (reset_n),
      .pinIn     ({refOscClock, bemfCmpC, bemfCmpB, bemfCmpA}),
      .stableOut (pinStable)
   );

   wire oscRise = pinStable[3] && !oscPrev_r;

   // ----------------------------------------
   // Sequencer and crossing detection
   // ----------------------------------------
   bscf_seq_t seq_r;
   logic      zct_r;
   logic      seen_r;
   logic      synced_r;
   bscf_tmr_t stCnt_r;
   bscf_tmr_t bwCnt_r;
   logic [5:0] drive_r;
   logic [1:0] fire;
   logic       commutate;

   // Floating phase and its expected level after the crossing
   wire [1:0] floatIdx   = (seq_r == SEQ_S2 || seq_r == SEQ_S5) ? 2'd0 :
                           (seq_r == SEQ_S3 || seq_r == SEQ_S6) ? 2'd1 : 2'd2;
   wire       expectHigh = (seq_r == SEQ_S1 || seq_r == SEQ_S3 || seq_r == SEQ_S5);
   wire       bemfSel    = pinStable[floatIdx];
   wire       blanking   = bwCnt_r < blankEff;
   wire       crossing   = runEn && !stepOnly && !blanking && !seen_r
                           && (bemfSel == expectHigh);
   wire       startFire  = runEn && (stCnt_r >= startLen_r);
   wire       wdFire     = runEn && !stepOnly && !seen_r && (bwCnt_r >= wdLen_r);
   wire       delayFire  = runEn && !stepOnly && (|fire);
   assign     commutate  = startFire || wdFire || delayFire;
   wire bscf_seq_t seqNxt = !runEn ? SEQ_S1 : commutate ? nextOf(seq_r) : seq_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         seq_r    <= SEQ_S1;
         drive_r  <= 6'b000000;
         zct_r    <= 1'b0;
         seen_r   <= 1'b0;
         synced_r <= 1'b0;
         oscPrev_r <= 1'b0;
      end else begin
         oscPrev_r <= pinStable[3];
         seq_r   <= seqNxt;
         drive_r <= runEn ? driveOf(seqNxt) : 6'b000000;
         if (crossing) zct_r <= !zct_r;
         seen_r  <= runEn && !commutate && (seen_r || crossing);
         if (!runEn || startFire || wdFire) synced_r <= 1'b0;
         else if (delayFire) synced_r <= 1'b1;
      end
   end

   // Both interval timers restart on every commutation
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stCnt_r <= 20'h00000;
         bwCnt_r <= 20'h00000;
      end else if (!runEn || commutate) begin
         stCnt_r <= 20'h00000;
         bwCnt_r <= 20'h00000;
      end else begin
         stCnt_r <= stCnt_r + 20'h00001;
         if (bwCnt_r != 20'hfffff) bwCnt_r <= bwCnt_r + 20'h00001;
      end
   end

   assign {phaseAOe, phaseAOut, phaseBOe, phaseBOut, phaseCOe, phaseCOut} = drive_r;
   assign seqState = seq_r;

   // ----------------------------------------
   // Adaptive commutation delay timers
   // ----------------------------------------
   // Index 0 works on the high level, index 1 on the low level
   bscf_tmr_t  dCnt_r [2];
   logic [1:0] acc_r;
   logic [1:0] dis_r;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_delay
         wire levelNow  = (gi == 0) ? zct_r : !zct_r;
         wire riseInto  = crossing && !levelNow;
         wire fallOut   = crossing && levelNow;
         // Draining stops at a threshold above zero, so commutation lands early
         assign fire[gi] = dis_r[gi] && (dCnt_r[gi] <= advThr_r);
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               dCnt_r[gi] <= 20'h00000;
               acc_r[gi]  <= 1'b0;
               dis_r[gi]  <= 1'b0;
            end else if (!runEn || stepOnly) begin
               acc_r[gi] <= 1'b0;
               dis_r[gi] <= 1'b0;
            end else if (riseInto) begin
               dCnt_r[gi] <= 20'h00000;
               acc_r[gi]  <= 1'b1;
               dis_r[gi]  <= 1'b0;
            end else if (fallOut && acc_r[gi]) begin
               acc_r[gi] <= 1'b0;
               dis_r[gi] <= 1'b1;
            end else if (fire[gi]) begin
               dis_r[gi] <= 1'b0;
            end else if (acc_r[gi] && dCnt_r[gi] != 20'hfffff) begin
               dCnt_r[gi] <= dCnt_r[gi] + 20'h00001;
            end else if (dis_r[gi]) begin
               dCnt_r[gi] <= (dCnt_r[gi] > 20'h00001) ? dCnt_r[gi] - 20'h00002 : 20'h00000;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Revolution signal and speed loop
   // ----------------------------------------
   logic [5:0] revCnt_r;
   logic       rev_r;
   logic       revPrev_r;
   logic       window;
   logic       windowFall;
   // Crossings per revolution are three times the pole count
   wire [5:0]  revCrossings = (poleSel == 2'b10) ? `BSCF_XING_16P :
                              (poleSel == 2'b11) ? `BSCF_XING_12P : `BSCF_XING_8P;
   wire        revRise = rev_r && !revPrev_r;
   wire        revFall = !rev_r && revPrev_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         revCnt_r  <= 6'h00;
         rev_r     <= 1'b0;
         revPrev_r <= 1'b0;
      end else begin
         revPrev_r <= rev_r;
         if (crossing) begin
            if (revCnt_r >= revCrossings - 6'h01) begin
               revCnt_r <= 6'h00;
               rev_r    <= !rev_r;
            end else begin
               revCnt_r <= revCnt_r + 6'h01;
            end
         end
      end
   end

   bscf_ref_window u_ref (
      .clk        (clk),
      .reset_n    (reset_n),
      .oscRise    (oscRise),
      .start      (revRise),
      .winLen     (winLen),
      .window     (window),
      .windowFall (windowFall)
   );

   // Revolution ending first means the motor runs fast
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         speedUp  <= 1'b0;
         slowDown <= 1'b0;
      end else begin
         if (revFall && window) slowDown <= 1'b1;
         else if (windowFall || !window) slowDown <= 1'b0;
         if (windowFall && rev_r) speedUp <= 1'b1;
         else if (revFall || !rev_r) speedUp <= 1'b0;
      end
   end

   // ----------------------------------------
   // Current limit and diagnostics
   // ----------------------------------------
   wire [10:0] ilimVal = (ilimSel == 2'b01) ? `BSCF_ILIM_1A :
                         (ilimSel == 2'b10) ? `BSCF_ILIM_800 :
                         (ilimSel == 2'b11) ? `BSCF_ILIM_600 : `BSCF_ILIM_SAT;
   // Thermal code reads low: that sensing lives outside this block
   wire        diagNxt = (diagSel == 2'b11) ? zct_r :
                         (diagSel == 2'b10) ? window :
                         (diagSel == 2'b00) ? rev_r : 1'b0;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         currentCmd <= 11'h000;
         diagOut    <= 1'b0;
      end else begin
         currentCmd <= (currentReq < ilimVal) ? currentReq : ilimVal;
         diagOut    <= diagNxt;
      end
   end

   assign statusWord = {22'h000000, synced_r, slowDown, speedUp, window,
                        blanking, rev_r, zct_r, seq_r};

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence commutS;
      commutate && runEn;
   endsequence
   sequence restartS;
      stCnt_r == 20'h00000 && bwCnt_r == 20'h00000;
   endsequence

   one_float_a: assert property ($past(runEn) |->
      $countones({phaseAOe, phaseBOe, phaseCOe}) == 2 &&
      $countones({phaseAOe & phaseAOut, phaseBOe & phaseBOut, phaseCOe & phaseCOut}) == 1)
      else $error("drive pattern broken");
   state_three_a: assert property (seq_r == SEQ_S3 && $past(runEn) |->
      drive_r == 6'b100011) else $error("state 3 drive wrong");
   seq_wrap_a: assert property (commutS |=> runEn |-> seq_r == nextOf($past(seq_r)))
      else $error("sequencer did not advance");
   toggle_flip_a: assert property (crossing |=> zct_r != $past(zct_r))
      else $error("toggle missed crossing");
   timer_restart_a: assert property (commutS |=> restartS)
      else $error("timers not restarted");
   blank_mask_a: assert property (commutS ##1 runEn [*2] |-> !crossing)
      else $error("crossing inside blanking");
   wd_fire_a: assert property (runEn && !stepOnly && !seen_r && bwCnt_r >= wdLen_r
      |=> bwCnt_r == 20'h00000 && seq_r == nextOf($past(seq_r))) else $error("watchdog missed");
   start_fire_a: assert property (runEn && stCnt_r >= startLen_r |-> ##1 restartS)
      else $error("startup expiry ignored");
   diag_toggle_a: assert property (diagSel == 2'b11 |=> diagOut == $past(zct_r))
      else $error("diag mux wrong");
   limit_1a_a: assert property (ilimSel == 2'b01 |=> currentCmd <= `BSCF_ILIM_1A)
      else $error("limit exceeded");
   ref_open_a: assert property (revRise && winLen != 18'h00000 |=> window)
      else $error("window not opened");
endmodule : bscf_top
